/* usu_pkg.sv */
// package: register map, field layout, timing and pin carriers
package usu_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SDA_DELAY_NS = 50;
  localparam int SDA_DELAY_CYC =
    (SDA_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADR_DATA = 4'h0;
  localparam logic [3:0] ADR_STAT = 4'h4;
  localparam logic [3:0] ADR_CTRL = 4'h8;

  localparam int STAT_START_BIT = 7;
  localparam int STAT_WRAP_BIT = 6;
  localparam int STAT_CNT_LSB = 0;
  localparam int CTRL_WM_LSB = 4;
  localparam int CTRL_CS_LSB = 2;
  localparam int CTRL_CLK_BIT = 1;
  localparam int CTRL_TGL_BIT = 0;

  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [1:0] CS_RST = 2'h0;
  localparam logic [3:0] CNT_MAX = 4'hf;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    WM_OFF = 2'h0,
    WM_THREE = 2'h1,
    WM_TWO = 2'h2,
    WM_TWO_HOLD = 2'h3
  } usu_wire_mode_t;

  localparam logic [1:0] CS_SOFT = 2'h0;
  localparam logic [1:0] CS_TIMER = 2'h1;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic scl;
    logic sda;
  } usu_pins_in_t;

  typedef struct packed {
    logic scl_o;
    logic scl_oe_n;
    logic sda_o;
    logic sda_oe_n;
    logic do_o;
    logic do_oe_n;
  } usu_pins_out_t;

  typedef struct packed {
    logic sda_bit;
    logic scl_dir;
    logic do_dir;
  } usu_port_t;

endpackage

/* usu_serial_unit.sv */
// universal serial shift unit: shift register, edge counter, start detector
`timescale 1ns/100ps

module usu_serial_unit
  import usu_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic tmr_match,
  input wire usu_port_t port_i,
  input wire usu_pins_in_t pins_i,
  output usu_pins_out_t pins_o,
  output logic start_seen
);

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [3:0] adr,
                               input logic [3:0] reg_adr);
    hit = (adr == reg_adr);
  endfunction

  logic ack_q;
  logic [31:0] rdat_q;
  wire req = wb_cyc_i & wb_stb_i;
  // writes land on the edge that also samples ack
  wire wr = req & ack_q & wb_we_i & wb_sel_i[0];
  wire wr_data = wr & hit(wb_adr_i, ADR_DATA);
  wire wr_stat = wr & hit(wb_adr_i, ADR_STAT);
  wire wr_ctrl = wr & hit(wb_adr_i, ADR_CTRL);

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // no glitch filter on purpose: only a plain two-stage sampler
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic scl_prev_q;
  wire scl_s = scl_sync_q[1];
  wire sda_s = sda_sync_q[1];
  wire scl_rise = scl_s & ~scl_prev_q;
  wire scl_fall = ~scl_s & scl_prev_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], pins_i.scl};
      sda_sync_q <= {sda_sync_q[0], pins_i.sda};
      scl_prev_q <= scl_s;
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  usu_wire_mode_t wm_q;
  logic [1:0] cs_q;
  logic scl_drv_q;
  wire sw_clk = wr_ctrl & wb_dat_i[CTRL_CLK_BIT];
  wire sw_tgl = wr_ctrl & wb_dat_i[CTRL_TGL_BIT];
  wire two_wire = (wm_q == WM_TWO) | (wm_q == WM_TWO_HOLD);
  wire three_wire = (wm_q == WM_THREE);
  wire ext_clk = cs_q[1];

  always_ff @(posedge clk) begin
    if (rst) begin
      wm_q <= WM_OFF;
      cs_q <= CS_RST;
      scl_drv_q <= 1'b1;
    end else begin
      if (wr_ctrl) begin
        wm_q <= usu_wire_mode_t'(wb_dat_i[CTRL_WM_LSB +: 2]);
        cs_q <= wb_dat_i[CTRL_CS_LSB +: 2];
      end
      if (sw_tgl) begin
        scl_drv_q <= ~scl_drv_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // clock source selection
  // ----------------------------------------------------------------
  // edges come from the pin in every wire mode, even with outputs off
  wire ext_shift = cs_q[0] ? scl_fall : scl_rise;
  wire shift_tick = (cs_q == CS_SOFT) ? sw_clk :
                    (cs_q == CS_TIMER) ? tmr_match : ext_shift;
  wire cnt_tick = (cs_q == CS_SOFT) ? sw_clk :
                  (cs_q == CS_TIMER) ? tmr_match :
                  (scl_rise | scl_fall);

  // ----------------------------------------------------------------
  // shift register and output latch
  // ----------------------------------------------------------------
  logic [7:0] sr_q;
  logic out_q;
  // a write beats a shift in the same cycle
  wire [7:0] sr_d = wr_data ? wb_dat_i[7:0] :
                    shift_tick ? {sr_q[6:0], sda_s} : sr_q;
  // open while the clock sits on the level before the sampling edge, and always without an external clock
  wire latch_open = ~ext_clk | (cs_q[0] ? scl_s : ~scl_s);

  always_ff @(posedge clk) begin
    if (rst) begin
      sr_q <= DATA_RST;
      out_q <= DATA_RST[7];
    end else begin
      sr_q <= sr_d;
      if (latch_open) begin
        out_q <= sr_d[7];
      end
    end
  end

  // ----------------------------------------------------------------
  // edge counter
  // ----------------------------------------------------------------
  logic [3:0] cnt_q;
  wire wr_cnt = wr_stat;
  wire wrap_evt = cnt_tick & (cnt_q == CNT_MAX) & ~wr_cnt;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= CNT_RST;
    end else if (wr_cnt) begin
      cnt_q <= wb_dat_i[STAT_CNT_LSB +: 4];
    end else if (cnt_tick) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // start detector
  // ----------------------------------------------------------------
  // the delayed data line lets the clock level settle before sampling
  logic [SDA_DELAY_CYC:0] sda_dly_q;
  wire start_det = two_wire & scl_s &
                   sda_dly_q[SDA_DELAY_CYC] &
                   ~sda_dly_q[SDA_DELAY_CYC-1];

  always_ff @(posedge clk) begin
    if (rst) begin
      sda_dly_q <= '1;
    end else begin
      sda_dly_q <= {sda_dly_q[SDA_DELAY_CYC-1:0], sda_s};
    end
  end

  // ----------------------------------------------------------------
  // flags and clock hold
  // ----------------------------------------------------------------
  logic start_q;
  logic wrap_q;
  logic hold_start_q;
  wire clr_start = wr_stat & wb_dat_i[STAT_START_BIT];
  wire clr_wrap = wr_stat & wb_dat_i[STAT_WRAP_BIT];
  // a new start event wins over a clear in the same cycle; a status write suppresses the wrap event
  wire start_d = start_det | (start_q & ~clr_start);
  wire wrap_d = wrap_evt | (wrap_q & ~clr_wrap);
  wire hold_start_d = two_wire & start_d &
                      (hold_start_q | (start_q & scl_fall));
  wire scl_hold = two_wire &
                  (hold_start_q | ((wm_q == WM_TWO_HOLD) & wrap_q));

  always_ff @(posedge clk) begin
    if (rst) begin
      start_q <= 1'b0;
      wrap_q <= 1'b0;
      hold_start_q <= 1'b0;
    end else begin
      start_q <= start_d;
      wrap_q <= wrap_d;
      hold_start_q <= hold_start_d;
    end
  end

  // flag is live without cpu help, usable as a wake request
  assign start_seen = start_q;

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  wire [31:0] stat_word = {24'h000000, start_q, wrap_q, 2'h0, cnt_q};
  wire [31:0] ctrl_word = {26'h0000000, wm_q, cs_q, 2'h0};
  wire [31:0] rmux = hit(wb_adr_i, ADR_DATA) ? {24'h000000, sr_q} :
                     hit(wb_adr_i, ADR_STAT) ? stat_word :
                     hit(wb_adr_i, ADR_CTRL) ? ctrl_word : 32'h00000000;

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q) begin
        rdat_q <= rmux;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  // open drain data: in two-wire mode released only when both latched bit 7 and port bit are one
  wire sda_low = two_wire & (~out_q | ~port_i.sda_bit);
  wire scl_low_2w = two_wire & (scl_hold | ~scl_drv_q);

  always_comb begin
    pins_o.sda_o = 1'b0;
    pins_o.sda_oe_n = ~sda_low;
    pins_o.scl_o = three_wire ? scl_drv_q : 1'b0;
    pins_o.scl_oe_n = ~(scl_low_2w | (three_wire & port_i.scl_dir));
    pins_o.do_o = out_q;
    pins_o.do_oe_n = ~(three_wire & port_i.do_dir);
  end

endmodule

/* usu_serial_unit_assertions.sv */
// checker: bus handshake, start flag and pin drive relations
`timescale 1ns/100ps
module usu_serial_unit_assertions
  import usu_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire usu_port_t port_i,
  input wire usu_pins_in_t pins_i,
  input wire usu_pins_out_t pins_o,
  input wire logic start_seen
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // sequences and properties
  // ----------------------------------------------------------------
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_flag_up;
    $rose(start_seen);
  endsequence
  a_ack_follows: assert property (s_req |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_no_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  // sda sampled three cycles back is still inside the start window
  a_start_cause: assert property (
    s_flag_up |-> $past(pins_i.scl, 3) && !$past(pins_i.sda, 3))
    else $error("start flag without start condition");
  a_start_sticky: assert property (
    start_seen && !(wb_ack_o && wb_we_i) |=> start_seen)
    else $error("start flag lost without a write");
  a_start_hold: assert property (
    $fell(pins_i.scl) && start_seen |-> ##[1:8] !pins_o.scl_oe_n)
    else $error("clock not held after start");
  a_sda_drain: assert property (pins_o.sda_o == 1'b0)
    else $error("data line driven high");
  a_do_enable: assert property (
    !pins_o.do_oe_n |-> port_i.do_dir || $past(port_i.do_dir))
    else $error("data out enabled without direction bit");
endmodule

bind usu_serial_unit usu_serial_unit_assertions u_chk (.clk, .rst,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .port_i, .pins_i, .pins_o,
  .start_seen);

/* usu_far_end.sv */
// two-wire master model: open-drain clock and data, released lines read 1
`timescale 1ns/100ps
module usu_far_end (
  input wire logic clk,
  input wire logic scl_line,
  output logic scl_rel,
  output logic sda_rel
);
  initial begin
    scl_rel = 1'b1;
    sda_rel = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic tog(input logic v);
    @(posedge clk) scl_rel <= v;
    w(8);
  endtask
  task automatic start();
    @(posedge clk) sda_rel <= 1'b0;
    w(16);
    tog(1'b0);
  endtask
  task automatic stop();
    tog(1'b1);
    @(posedge clk) sda_rel <= 1'b1;
    w(8);
  endtask
  task automatic put_bit(input logic b);
    int n;
    @(posedge clk) sda_rel <= b;
    w(8);
    scl_rel <= 1'b1;
    n = 0;
    // the slave may stretch, so wait for the line itself
    while (scl_line !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    w(8);
    tog(1'b0);
  endtask
endmodule

/* testbench.sv */
// self-checking bench for the serial shift unit
`timescale 1ns/100ps
module testbench
  import usu_pkg::*;
;
  logic clk, rst, cyc, stb, we, tmr_match, start_seen, ack;
  logic [3:0] adr;
  logic [31:0] dati, dato;
  logic [2:0] port;
  logic [31:0] seed;
  logic [7:0] r, b, q;
  int err_total, check_count, i;
  wire logic m_scl, m_sda;
  usu_pins_out_t pins_o;
  wire logic scl_line = m_scl & (pins_o.scl_oe_n | pins_o.scl_o);
  wire logic sda_line = m_sda & (pins_o.sda_oe_n | pins_o.sda_o);
  usu_serial_unit dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(dati), .wb_dat_o(dato), .wb_ack_o(ack),
    .tmr_match(tmr_match), .port_i(usu_port_t'(port)),
    .pins_i(usu_pins_in_t'({scl_line, sda_line})), .pins_o(pins_o),
    .start_seen(start_seen));
  usu_far_end far (.clk(clk), .scl_line(scl_line), .scl_rel(m_scl),
    .sda_rel(m_sda));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [7:0] shl(input logic [7:0] v);
    return {v[6:0], 1'b1};
  endfunction
  // idle data line reads one, so every shift brings in a one
  function automatic logic [7:0] shn(input logic [7:0] v, input int n);
    logic [7:0] t;
    t = v;
    for (int k = 0; k < n; k++) t = shl(t);
    return t;
  endfunction
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dati <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = dato[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] e, string nm);
    wb(1'b0, a, 8'h00);
    chk(nm, e, q);
  endtask
  task automatic pulse();
    @(posedge clk) tmr_match <= 1'b1;
    @(posedge clk) tmr_match <= 1'b0;
  endtask
  task automatic end_of_test();
    if (err_total == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_of_test();
  end
  initial begin
    {rst, cyc, stb, we, tmr_match} = 5'h10;
    adr = 4'h0;
    dati = 32'h0;
    port = 3'b101;
    err_total = 0;
    check_count = 0;
    seed = 32'h87e6;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rc(ADR_DATA, DATA_RST, "data");
    rc(ADR_STAT, 8'h00, "stat");
    rc(ADR_CTRL, 8'h00, "ctrl");
    rc(4'hc, 8'h00, "unmapped");
    seed = xs(seed);
    r = seed[7:0];
    wb(1'b1, ADR_DATA, r);
    wb(1'b1, ADR_CTRL, 8'h02);
    rc(ADR_DATA, shl(r), "strobe shift");
    rc(ADR_STAT, 8'h01, "strobe count");
    wb(1'b1, ADR_STAT, 8'h0f);
    wb(1'b1, ADR_CTRL, 8'h02);
    rc(ADR_STAT, 8'h40, "strobe wrap");
    wb(1'b1, ADR_CTRL, 8'h04);
    wb(1'b1, ADR_STAT, 8'h40);
    // the tick lands on the very edge that commits the write
    fork
      wb(1'b1, ADR_DATA, r);
      begin
        repeat (2) @(posedge clk);
        tmr_match <= 1'b1;
        @(posedge clk) tmr_match <= 1'b0;
      end
    join
    rc(ADR_DATA, r, "write over shift");
    for (i = 0; i <= seed[9:8]; i++) pulse();
    rc(ADR_STAT, 8'h02 + seed[9:8], "timer count");
    wb(1'b1, ADR_CTRL, 8'h08);
    wb(1'b1, ADR_STAT, 8'h4f);
    far.tog(1'b0);
    rc(ADR_STAT, 8'h40, "edge wrap");
    far.tog(1'b1);
    rc(ADR_STAT, 8'h41, "both edges");
    // timer pulses also shifted, plus the one rising pin edge
    rc(ADR_DATA, shn(r, seed[9:8] + 2), "mode off shift");
    wb(1'b1, ADR_CTRL, 8'h18);
    far.start();
    chk("start in three-wire", 8'h00, {7'h0, start_seen});
    far.stop();
    wb(1'b1, ADR_DATA, 8'hff);
    wb(1'b1, ADR_CTRL, 8'h38);
    wb(1'b1, ADR_STAT, 8'hc0);
    far.start();
    chk("start flag", 8'h01, {7'h0, start_seen});
    chk("start hold", 8'h00, {7'h0, pins_o.scl_oe_n});
    chk("sda release", 8'h01, {7'h0, pins_o.sda_oe_n});
    wb(1'b1, ADR_STAT, 8'h80);
    seed = xs(seed);
    b = seed[7:0];
    for (i = 7; i >= 0; i--) far.put_bit(b[i]);
    chk("wrap hold", 8'h00, {7'h0, pins_o.scl_oe_n});
    chk("sda bit7", {7'h0, b[7]}, {7'h0, pins_o.sda_oe_n});
    chk("out latch", {7'h0, b[7]}, {7'h0, pins_o.do_o});
    rc(ADR_DATA, b, "rx byte");
    rc(ADR_STAT, 8'h40, "byte wrap");
    wb(1'b1, ADR_STAT, 8'h4e);
    far.put_bit(1'b0);
    rc(ADR_STAT, 8'h40, "ack wrap");
    end_of_test();
  end
endmodule
